// [wdog_option_latches.sv]
/*
 Watchdog with write-once option latches, APB slave, one clock (oscillator clock).
 Assumes pclk is the oscillator clock; por_n marks power-on reset, presetn any reset.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module wdog_option_latches #(
   parameter int POR_CYCLES = wdog_pkg::POR_CLEAR_CYC,
   parameter int LONG_CYCLES = wdog_pkg::LONG_REC_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_exec,
   input wire logic stop_exit,
   input wire logic stop_exit_by_pin,
   input wire logic vector_fetch,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic test_voltage_on_reset,
   input wire logic test_voltage_on_irq,
   input wire logic monitor_reset_req,
   output logic reset_pin_low,
   output logic monitor_reset,
   output logic monitor_power_on,
   output logic monitor_stop_on,
   output logic monitor_5v_mode,
   output logic oscillator_stop,
   output logic serial_clock_source_option,
   output logic illegal_stop,
   output logic stop_recovery_busy
);
   import wdog_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Option latches
   logic [7:0] option_register_one;
   logic [7:0] option_register_two;
   logic lv_mode;
   logic lock_one;
   logic lock_two;
   logic lock_lv;
   logic wdog_cause;
   logic stop_req;

   wire wr_access = psel && penable && pwrite;
   wire rd_access = psel && penable && !pwrite;
   wire hit_one = (paddr == ADDR_OPT_ONE);
   wire hit_two = (paddr == ADDR_OPT_TWO);
   wire hit_svc = (paddr == ADDR_SERVICE);
   wire hit_sts = (paddr == ADDR_STATUS);
   wire hit_ctl = (paddr == ADDR_CONTROL);
   wire mapped = hit_one | hit_two | hit_svc | hit_sts | hit_ctl;
   wire wr_one = wr_access && hit_one && !lock_one;
   wire wr_two = wr_access && hit_two && !lock_two;
   wire wr_lv = wr_access && hit_one && !lock_lv;
   wire service_wr = wr_access && hit_svc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         option_register_one <= OPT_RESET;
         option_register_two <= OPT_RESET;
         lock_one <= 1'b0;
         lock_two <= 1'b0;
         stop_req <= 1'b0;
      end else begin
         if (wr_one) begin
            option_register_one <= pwdata[7:0];
            lock_one <= 1'b1;
         end
         if (wr_two) begin
            option_register_two <= pwdata[7:0];
            lock_two <= 1'b1;
         end
         if (wr_access && hit_ctl) begin
            stop_req <= pwdata[BIT_STOP_REQ];
         end
      end
   end

   // Mode select survives all but power-on reset
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         lv_mode <= LV_MODE_RESET;
         lock_lv <= 1'b0;
      end else if (wr_lv) begin
         lv_mode <= pwdata[BIT_LV_MODE];
         lock_lv <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Option decode
   wire opt_rate = option_register_one[BIT_WDOG_RATE];
   wire opt_mon_stop = option_register_one[BIT_MON_STOP];
   wire opt_mon_rst_dis = option_register_one[BIT_MON_RST_DIS];
   wire opt_mon_pwr_dis = option_register_one[BIT_MON_PWR_DIS];
   wire opt_short = option_register_one[BIT_SHORT_REC];
   wire opt_stop_en = option_register_one[BIT_STOP_EN];
   wire opt_wdog_dis = option_register_one[BIT_WDOG_DIS];

   assign oscillator_stop = stop_req && !option_register_two[BIT_OSC_STOP];
   assign serial_clock_source_option = option_register_two[BIT_SER_CLK_SRC];
   assign monitor_stop_on = opt_mon_stop && !opt_mon_pwr_dis;
   assign monitor_reset = monitor_reset_req && !opt_mon_rst_dis;
   assign monitor_power_on = !opt_mon_pwr_dis;
   assign monitor_5v_mode = lv_mode;
   assign illegal_stop = stop_exec && !opt_stop_en;

   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   logic [PRESCALE_BITS-1:0] prescale;
   logic [COUNT_BITS-1:0] count;
   logic [12:0] por_count;
   logic por_done;
   logic [5:0] pulse_count;
   logic [12:0] rec_count;

   wire test_hold = (monitor_mode && (test_voltage_on_reset || test_voltage_on_irq))
                    || (break_state && test_voltage_on_reset);
   wire wdog_run = !opt_wdog_dis && !test_hold && por_done;
   wire pulse_busy = (pulse_count != 6'd0);
   // Short rate: counter advances every 2^7 cycles, long every 2^12
   wire tick = opt_rate ? (prescale[6:0] == 7'h7F) : (prescale == 12'hFFF);
   // Overflow on the last cycle of the timeout span
   wire at_short_end = ({count, prescale[6:0]} == 13'(TIMEOUT_SHORT - 1));
   wire at_long_end = ({count, prescale} == 18'(TIMEOUT_LONG - 1));
   wire overflow = wdog_run && (opt_rate ? at_short_end : at_long_end);
   wire por_clear = !por_done && (por_count == 13'(POR_CYCLES - 1));
   wire full_clear = stop_exec || vector_fetch || por_clear;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= '0;
         count <= '0;
      end else if (full_clear || overflow) begin
         prescale <= '0;
         if (overflow) begin
            count <= '0;
         end
      end else if (service_wr) begin
         prescale[11:4] <= 8'h00;
         count <= '0;
      end else if (wdog_run) begin
         prescale <= prescale + 12'd1;
         if (tick) begin
            count <= count + 6'd1;
         end
      end
   end

   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         por_count <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_count <= por_count + 13'd1;
         por_done <= por_clear;
      end
   end

   // Reset pulse and cause flag live across the chip reset they cause
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         pulse_count <= '0;
         wdog_cause <= 1'b0;
      end else if (overflow) begin
         pulse_count <= 6'(RST_PULSE_CYC);
         wdog_cause <= 1'b1;
      end else begin
         if (pulse_busy) begin
            pulse_count <= pulse_count - 6'd1;
         end
         if (rd_access && hit_sts) begin
            wdog_cause <= 1'b0;
         end
      end
   end
   assign reset_pin_low = pulse_busy;

   ////////////////////////////////////////////////////////////////////////
   // Stop recovery delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_count <= '0;
      end else if (stop_exit) begin
         rec_count <= (opt_short && !stop_exit_by_pin) ? 13'(SHORT_REC_CYC) : 13'(LONG_CYCLES);
      end else if (rec_count != 13'd0) begin
         rec_count <= rec_count - 13'd1;
      end
   end
   assign stop_recovery_busy = (rec_count != 13'd0);

   ////////////////////////////////////////////////////////////////////////
   // APB read path
   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_one) begin
         next_prdata[7:0] = {option_register_one[7:5], lv_mode, option_register_one[3:0]};
      end else if (hit_two) begin
         next_prdata[7:0] = option_register_two;
      end else if (hit_svc) begin
         next_prdata[7:0] = RESET_VECTOR_LOW;
      end else if (hit_sts) begin
         next_prdata[BIT_WDOG_CAUSE] = wdog_cause;
      end else if (hit_ctl) begin
         next_prdata[BIT_STOP_REQ] = stop_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= next_prdata;
      end
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_lock_one;
      @(posedge pclk) disable iff (!presetn)
      lock_one && !($past(wr_one)) |-> $stable(option_register_one);
   endproperty
   a_lock_one: assert property (p_lock_one) else $error("option one changed after lock");

   property p_first_write;
      @(posedge pclk) disable iff (!presetn)
      wr_one |=> option_register_one == $past(pwdata[7:0]) && lock_one;
   endproperty
   a_first_write: assert property (p_first_write) else $error("first write not taken");

   property p_pulse;
      @(posedge pclk) disable iff (!por_n)
      overflow |=> reset_pin_low [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse too short");

   property p_cause;
      @(posedge pclk) disable iff (!por_n)
      overflow |=> wdog_cause;
   endproperty
   a_cause: assert property (p_cause) else $error("cause flag not set");

   property p_disable;
      @(posedge pclk) disable iff (!presetn)
      opt_wdog_dis && !full_clear && !service_wr |=> $stable(prescale) && $stable(count);
   endproperty
   a_disable: assert property (p_disable) else $error("disabled watchdog overflowed");

   property p_service;
      @(posedge pclk) disable iff (!presetn)
      service_wr && !full_clear && !overflow |=> count == 6'd0 && prescale[11:4] == 8'h00;
   endproperty
   a_service: assert property (p_service) else $error("service did not clear");

   property p_stop_clear;
      @(posedge pclk) disable iff (!presetn)
      stop_exec |=> prescale == 12'h000;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear prescaler");

   property p_pin_long;
      @(posedge pclk) disable iff (!presetn)
      stop_exit && stop_exit_by_pin |=> rec_count == 13'(LONG_CYCLES);
   endproperty
   a_pin_long: assert property (p_pin_long) else $error("pin exit not long");

   property p_illegal;
      @(posedge pclk) disable iff (!presetn)
      stop_exec && !option_register_one[BIT_STOP_EN] |-> illegal_stop;
   endproperty
   a_illegal: assert property (p_illegal) else $error("stop not illegal");

   property p_lock_two;
      @(posedge pclk) disable iff (!presetn)
      lock_two && !($past(wr_two)) |-> $stable(option_register_two);
   endproperty
   a_lock_two: assert property (p_lock_two) else $error("option two changed after lock");

   property p_first_two;
      @(posedge pclk) disable iff (!presetn)
      wr_two |=> option_register_two == $past(pwdata[7:0]) && lock_two;
   endproperty
   a_first_two: assert property (p_first_two) else $error("first write to option two not taken");

   property p_mode_first;
      @(posedge pclk) disable iff (!por_n)
      wr_lv |=> lv_mode == $past(pwdata[BIT_LV_MODE]) && lock_lv;
   endproperty
   a_mode_first: assert property (p_mode_first) else $error("mode select write not taken");

   property p_mode_lock;
      @(posedge pclk) disable iff (!por_n)
      lock_lv |=> lv_mode == $past(lv_mode);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode select changed after lock");

   property p_reset_clear;
      @(posedge pclk)
      $rose(presetn) |-> option_register_one == OPT_RESET && option_register_two == OPT_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("options not cleared by reset");

   property p_por_clear;
      @(posedge pclk) disable iff (!presetn)
      por_clear |=> prescale == 12'h000;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-on timer did not clear prescaler");

   property p_vector_clear;
      @(posedge pclk) disable iff (!presetn)
      vector_fetch |=> prescale == 12'h000;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("vector fetch did not clear prescaler");

   property p_overflow_clear;
      @(posedge pclk) disable iff (!presetn)
      overflow |=> count == 6'h00 && prescale == 12'h000;
   endproperty
   a_overflow_clear: assert property (p_overflow_clear) else $error("internal reset did not clear watchdog");

   property p_pulse_len;
      @(posedge pclk) disable iff (!por_n)
      overflow |-> ##32 reset_pin_low ##1 !reset_pin_low;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

   property p_service_read;
      @(posedge pclk) disable iff (!presetn)
      rd_access && hit_svc && wdog_run && !full_clear && !overflow |=> prescale == $past(prescale) + 12'd1;
   endproperty
   a_service_read: assert property (p_service_read) else $error("service read touched watchdog");

   property p_test_hold;
      @(posedge pclk) disable iff (!presetn)
      test_hold && !full_clear && !service_wr |=> $stable(prescale) && $stable(count);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("watchdog ran under test voltage");

   property p_recovery;
      @(posedge pclk) disable iff (!presetn)
      stop_exit && !stop_exit_by_pin |=> rec_count == ($past(opt_short) ? 13'(SHORT_REC_CYC) : 13'(LONG_CYCLES));
   endproperty
   a_recovery: assert property (p_recovery) else $error("stop recovery delay wrong");
endmodule

// [wdog_pkg.sv]
/*
 Package for the watchdog with write-once option latches: register offsets,
 option bit positions, reset values and cycle counts.
 Assumes a 32-bit APB slave with byte addresses, one register per word.
*/
package wdog_pkg;
   // Register indices, and byte addresses at four times the index
   localparam logic [15:0] IDX_OPT_TWO = 16'h001E;
   localparam logic [15:0] IDX_OPT_ONE = 16'h001F;
   localparam logic [15:0] IDX_SERVICE = 16'hFFFF;
   localparam logic [17:0] ADDR_OPT_TWO = {IDX_OPT_TWO, 2'b00};
   localparam logic [17:0] ADDR_OPT_ONE = {IDX_OPT_ONE, 2'b00};
   localparam logic [17:0] ADDR_SERVICE = {IDX_SERVICE, 2'b00};
   localparam logic [17:0] ADDR_STATUS = 18'h00080;
   localparam logic [17:0] ADDR_CONTROL = 18'h00084;
   // Option register one bit positions
   localparam int BIT_WDOG_RATE = 0;
   localparam int BIT_MON_STOP = 1;
   localparam int BIT_MON_RST_DIS = 2;
   localparam int BIT_MON_PWR_DIS = 3;
   localparam int BIT_LV_MODE = 4;
   localparam int BIT_SHORT_REC = 5;
   localparam int BIT_STOP_EN = 6;
   localparam int BIT_WDOG_DIS = 7;
   // Option register two bit positions
   localparam int BIT_SER_CLK_SRC = 0;
   localparam int BIT_OSC_STOP = 1;
   // Status / control bit positions
   localparam int BIT_WDOG_CAUSE = 0;
   localparam int BIT_STOP_REQ = 0;
   // Reset values
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam logic LV_MODE_RESET = 1'b0;
   // Cycle counts
   localparam int PRESCALE_BITS = 12;
   localparam int COUNT_BITS = 6;
   localparam int RST_PULSE_CYC = 32;
   localparam int SHORT_REC_CYC = 32;
   localparam int LONG_REC_CYC = 4096;
   localparam int POR_CLEAR_CYC = 4096;
   localparam int TIMEOUT_SHORT = (2 ** 13) - (2 ** 4);
   localparam int TIMEOUT_LONG = (2 ** 18) - (2 ** 4);
   localparam logic [7:0] RESET_VECTOR_LOW = 8'h00;
endpackage

// [testbench.sv]
/*
 Self-checking testbench for the watchdog with write-once option latches.
 Assumes wdog_pkg and the design module are compiled first; APB master driven at pclk rising edges.
*/
`timescale 1ns/1ps
module testbench;
   import wdog_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic por_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic stop_exec = 1'b0;
   logic stop_exit = 1'b0;
   logic stop_exit_by_pin = 1'b0;
   logic vector_fetch = 1'b0;
   logic monitor_mode = 1'b0;
   logic break_state = 1'b0;
   logic tv_rst = 1'b0;
   logic tv_irq = 1'b0;
   logic monitor_reset_req = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, reset_pin_low, monitor_reset, monitor_power_on, monitor_stop_on;
   logic monitor_5v_mode, oscillator_stop, serial_clock_source_option, illegal_stop, stop_recovery_busy;
   logic [31:0] rv;
   logic ev;
   int n_fail = 0;
   int comparisons = 0;
   localparam int SIM_CYCLES = 16;
   always #12.5 pclk = ~pclk;
   wdog_option_latches #(.POR_CYCLES(SIM_CYCLES), .LONG_CYCLES(SIM_CYCLES)) i_dut (.pclk(pclk), .presetn(presetn),
      .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_exec(stop_exec), .stop_exit(stop_exit),
      .stop_exit_by_pin(stop_exit_by_pin), .vector_fetch(vector_fetch), .monitor_mode(monitor_mode),
      .break_state(break_state), .test_voltage_on_reset(tv_rst), .test_voltage_on_irq(tv_irq),
      .monitor_reset_req(monitor_reset_req), .reset_pin_low(reset_pin_low), .monitor_reset(monitor_reset),
      .monitor_power_on(monitor_power_on), .monitor_stop_on(monitor_stop_on), .monitor_5v_mode(monitor_5v_mode),
      .oscillator_stop(oscillator_stop), .serial_clock_source_option(serial_clock_source_option),
      .illegal_stop(illegal_stop), .stop_recovery_busy(stop_recovery_busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer, read data and error kept in rv and ev
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         chk("pready", pready, 1);
         test_done();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [17:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk(nm, rv, exp);
   endtask
   task automatic rst(input logic por);
      @(posedge pclk);
      presetn <= 1'b0;
      por_n <= !por;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask
   task automatic quiet(input int n, input string nm);
      logic hit;
      hit = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         #1;
         if (reset_pin_low !== 1'b0) hit = 1'b1;
      end
      chk(nm, hit, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_latch();
      rst(1'b1);
      rd_chk("opt one reset", ADDR_OPT_ONE, 0);
      rd_chk("opt two reset", ADDR_OPT_TWO, 0);
      apb(1'b1, ADDR_OPT_ONE, 8'h10);
      rd_chk("opt one first", ADDR_OPT_ONE, 32'h10);
      rst(1'b0);
      rd_chk("mode kept", ADDR_OPT_ONE, 32'h10);
      apb(1'b1, ADDR_OPT_ONE, 8'h01);
      rd_chk("mode locked", ADDR_OPT_ONE, 32'h11);
      apb(1'b1, ADDR_OPT_ONE, 8'h02);
      rd_chk("opt one lock", ADDR_OPT_ONE, 32'h11);
      apb(1'b1, ADDR_OPT_TWO, 8'h03);
      apb(1'b1, ADDR_OPT_TWO, 8'h00);
      rd_chk("opt two lock", ADDR_OPT_TWO, 32'h03);
      rd_chk("service read", ADDR_SERVICE, {24'h000000, RESET_VECTOR_LOW});
      apb(1'b0, 18'h00100, 8'h00);
      chk("unmapped error", ev, 1);
      rst(1'b1);
      rd_chk("mode por clear", ADDR_OPT_ONE, 0);
      $display("test latch done");
   endtask
   task automatic t_decode();
      logic [7:0] o1 [3] = '{8'h72, 8'h0C, 8'h6A};
      logic [7:0] o2 [3] = '{8'h01, 8'h02, 8'h00};
      logic pin [3] = '{1'b0, 1'b0, 1'b1};
      int n;
      for (int i = 0; i < 3; i++) begin
         rst(1'b1);
         apb(1'b1, ADDR_OPT_ONE, o1[i]);
         apb(1'b1, ADDR_OPT_TWO, o2[i]);
         monitor_reset_req <= 1'b1;
         stop_exec <= 1'b1;
         @(posedge pclk);
         #1;
         chk("illegal stop", illegal_stop, !o1[i][6]);
         chk("mon power", monitor_power_on, !o1[i][3]);
         chk("mon stop", monitor_stop_on, o1[i][1] & !o1[i][3]);
         chk("mon reset", monitor_reset, !o1[i][2]);
         chk("mon 5v", monitor_5v_mode, o1[i][4]);
         chk("serial clk", serial_clock_source_option, o2[i][0]);
         @(posedge pclk);
         stop_exec <= 1'b0;
         apb(1'b1, ADDR_CONTROL, 8'h01);
         #1;
         chk("osc stop", oscillator_stop, !o2[i][1]);
         @(posedge pclk);
         stop_exit_by_pin <= pin[i];
         stop_exit <= 1'b1;
         @(posedge pclk);
         stop_exit <= 1'b0;
         n = 0;
         repeat (100) begin
            #1;
            if (stop_recovery_busy === 1'b1) n++;
            @(posedge pclk);
         end
         chk("recovery", n, (pin[i] || !o1[i][5]) ? SIM_CYCLES : SHORT_REC_CYC);
         apb(1'b1, ADDR_CONTROL, 8'h00);
         stop_exit_by_pin <= 1'b0;
         monitor_reset_req <= 1'b0;
      end
      $display("test decode done");
   endtask
   task automatic t_timeout();
      int n;
      rst(1'b1);
      apb(1'b1, ADDR_OPT_ONE, 8'h01);
      repeat (3) begin
         apb(1'b1, ADDR_SERVICE, 8'hA5);
         quiet(4000, "serviced quiet");
      end
      apb(1'b1, ADDR_SERVICE, 8'h5A);
      n = 0;
      while (reset_pin_low !== 1'b1 && n < 9000) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("timeout window", (n >= TIMEOUT_SHORT - 15 && n <= TIMEOUT_SHORT), 1);
      if (n >= 9000) test_done();
      n = 0;
      while (reset_pin_low === 1'b1 && n < 100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("pin low cycles", n, RST_PULSE_CYC);
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk("cause flag", rv[BIT_WDOG_CAUSE], 1);
      vector_fetch <= 1'b1;
      @(posedge pclk);
      vector_fetch <= 1'b0;
      @(posedge pclk);
      $display("test timeout done");
   endtask
   task automatic t_quiet();
      rst(1'b1);
      apb(1'b1, ADDR_OPT_ONE, 8'h81);
      quiet(9000, "disabled quiet");
      rst(1'b1);
      monitor_mode <= 1'b1;
      tv_irq <= 1'b1;
      apb(1'b1, ADDR_OPT_ONE, 8'h01);
      quiet(9000, "monitor quiet");
      monitor_mode <= 1'b0;
      tv_irq <= 1'b0;
      rst(1'b1);
      break_state <= 1'b1;
      tv_rst <= 1'b1;
      apb(1'b1, ADDR_OPT_ONE, 8'h01);
      quiet(9000, "break quiet");
      break_state <= 1'b0;
      tv_rst <= 1'b0;
      $display("test quiet done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      repeat (20) @(posedge pclk);
      t_latch();
      t_decode();
      t_timeout();
      t_quiet();
      test_done();
   end
endmodule
